// ---- ppp_primary_port.sv ----
// Primary PCI port: master, config target, parity and error reporting
`timescale 1ns/1ps
module ppp_primary_port (
   input  wire logic                      clk,
   input  wire logic                      rst_b,
   input  wire ppp_pkg::ppp_pins_in_type  pin_in,
   output ppp_pkg::ppp_pins_out_type      pin_out,
   input  wire logic                      mst_req,
   input  wire ppp_pkg::ppp_mst_req_type  mst_req_data,
   output logic                           mst_busy_q,
   output logic                           mst_done_q,
   output logic                           mst_abort_q,
   output logic                           mst_stopped_q,
   output logic [31:0]                    mst_rdata_q,
   input  wire logic                      tgt_retry,
   input  wire logic [31:0]               cfg_rdata,
   output logic [5:0]                     cfg_reg_q,
   output logic [31:0]                    cfg_wdata_q,
   output logic [3:0]                     cfg_be_q,
   output logic                           cfg_wr_q,
   input  wire logic                      secondary_system_error_n,
   input  wire logic                      dt_master_timeout
);
   ppp_pkg::ppp_mst_state_type mst_q, mst_d;
   ppp_pkg::ppp_tgt_state_type tgt_q, tgt_d;
   ppp_pkg::ppp_mst_req_type   req_q;
   logic [2:0]  cnt_q;
   logic [31:0] ad_o_q, cfg_rdata_q;
   logic [3:0]  cbe_o_q;
   logic        ad_oe_q, cbe_oe_q, par_o_q, par_oe_q, frame_o_q, frame_oe_q;
   logic        irdy_o_q, irdy_oe_q, trdy_o_q, trdy_oe_q, devsel_o_q, devsel_oe_q;
   logic        stop_o_q, stop_oe_q, perr_o_q, perr_oe_q, serr_o_q, serr_oe_q;
   logic        frame_prev_q, write_q, retry_q, data_chk_q, data_par_q;
   logic        addr_chk_q, addr_par_q, ss_meta_q, ss_sync_q;
   logic        addr_phase, tgt_claim, tgt_xfer, mst_rx, mst_end, mst_timeout;
   logic        data_perr, addr_perr;

   assign pin_out = '{ad_o: ad_o_q, ad_oe: ad_oe_q, cbe_o: cbe_o_q, cbe_oe: cbe_oe_q,
                      par_o: par_o_q, par_oe: par_oe_q, frame_o: frame_o_q,
                      frame_oe: frame_oe_q, irdy_o: irdy_o_q, irdy_oe: irdy_oe_q,
                      trdy_o: trdy_o_q, trdy_oe: trdy_oe_q, devsel_o: devsel_o_q,
                      devsel_oe: devsel_oe_q, stop_o: stop_o_q, stop_oe: stop_oe_q,
                      perr_o: perr_o_q, perr_oe: perr_oe_q, serr_o: serr_o_q,
                      serr_oe: serr_oe_q};

   // Bus decode
   assign addr_phase = !pin_in.frame_n && frame_prev_q;
   assign tgt_claim  = addr_phase && pin_in.primary_config_select &&
                       (pin_in.cbe == ppp_pkg::CMD_CFG_READ ||
                        pin_in.cbe == ppp_pkg::CMD_CFG_WRITE) &&
                       pin_in.ad[1:0] == ppp_pkg::CFG_TYPE0 &&
                       tgt_q == ppp_pkg::T_IDLE && mst_q == ppp_pkg::M_IDLE;
   assign tgt_xfer   = tgt_q == ppp_pkg::T_DATA && !pin_in.primary_initiator_ready_n &&
                       !trdy_o_q;
   assign mst_end    = !pin_in.primary_device_select_n &&
                       (!pin_in.primary_target_ready_n || !pin_in.stop_n);
   assign mst_timeout = pin_in.primary_device_select_n &&
                        cnt_q == ppp_pkg::DEVSEL_WAIT_CYC;
   assign mst_rx     = mst_q == ppp_pkg::M_DATA && !req_q.cmd[ppp_pkg::CMD_WRITE_BIT] &&
                       !pin_in.primary_device_select_n && !pin_in.primary_target_ready_n;
   assign data_perr  = data_chk_q && (data_par_q != pin_in.primary_parity);
   assign addr_perr  = addr_chk_q && (addr_par_q != pin_in.primary_parity);

   // Master sequencer
   always_comb begin
      mst_d = mst_q;
      case (mst_q)
         ppp_pkg::M_IDLE: begin
            if (mst_req && pin_in.frame_n && pin_in.primary_initiator_ready_n &&
                pin_in.lock_n && tgt_q == ppp_pkg::T_IDLE) begin
               mst_d = ppp_pkg::M_ADDR;
            end
         end
         ppp_pkg::M_ADDR: mst_d = ppp_pkg::M_DATA;
         ppp_pkg::M_DATA: begin
            if (mst_end || mst_timeout) begin
               mst_d = ppp_pkg::M_TURN;
            end
         end
         default: mst_d = ppp_pkg::M_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mst_q <= ppp_pkg::M_IDLE;
         cnt_q <= 3'h0;
      end else begin
         mst_q <= mst_d;
         if (mst_q == ppp_pkg::M_ADDR) begin
            cnt_q <= ppp_pkg::CNT_FIRST;
         end else if (mst_q == ppp_pkg::M_DATA && cnt_q != ppp_pkg::DEVSEL_WAIT_CYC) begin
            cnt_q <= cnt_q + 3'h1;
         end
      end
   end

   // Master request and result
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         req_q         <= '0;
         mst_busy_q    <= 1'b0;
         mst_done_q    <= 1'b0;
         mst_abort_q   <= 1'b0;
         mst_stopped_q <= 1'b0;
         mst_rdata_q   <= 32'h0;
      end else begin
         if (mst_q == ppp_pkg::M_IDLE && mst_d == ppp_pkg::M_ADDR) begin
            req_q <= mst_req_data;
         end
         mst_busy_q <= mst_d != ppp_pkg::M_IDLE;
         mst_done_q <= mst_q == ppp_pkg::M_DATA && mst_d == ppp_pkg::M_TURN;
         if (mst_q == ppp_pkg::M_DATA && mst_d == ppp_pkg::M_TURN) begin
            mst_abort_q   <= !mst_end;
            mst_stopped_q <= mst_end && !pin_in.stop_n;
         end
         if (mst_rx) begin
            mst_rdata_q <= pin_in.ad;
         end
      end
   end

   // Master control pins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_o_q  <= 1'b1;
         frame_oe_q <= 1'b0;
         irdy_o_q   <= 1'b1;
         irdy_oe_q  <= 1'b0;
      end else begin
         frame_o_q  <= mst_d != ppp_pkg::M_ADDR;
         frame_oe_q <= mst_d == ppp_pkg::M_ADDR || mst_q == ppp_pkg::M_ADDR;
         irdy_o_q   <= mst_d != ppp_pkg::M_DATA;
         irdy_oe_q  <= mst_d == ppp_pkg::M_DATA || mst_d == ppp_pkg::M_TURN;
      end
   end

   // Config target sequencer
   always_comb begin
      tgt_d = tgt_q;
      case (tgt_q)
         ppp_pkg::T_IDLE: begin
            if (tgt_claim) begin
               tgt_d = ppp_pkg::T_DECODE;
            end
         end
         ppp_pkg::T_DECODE: tgt_d = ppp_pkg::T_DATA;
         ppp_pkg::T_DATA: begin
            if (!pin_in.primary_initiator_ready_n && (!trdy_o_q || !stop_o_q)) begin
               tgt_d = pin_in.frame_n ? ppp_pkg::T_TURN : ppp_pkg::T_HOLD;
            end
         end
         ppp_pkg::T_HOLD: begin
            if (!pin_in.primary_initiator_ready_n && pin_in.frame_n) begin
               tgt_d = ppp_pkg::T_TURN;
            end
         end
         default: tgt_d = ppp_pkg::T_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tgt_q       <= ppp_pkg::T_IDLE;
         write_q     <= 1'b0;
         retry_q     <= 1'b0;
         cfg_reg_q   <= 6'h0;
         cfg_rdata_q <= 32'h0;
      end else begin
         tgt_q <= tgt_d;
         if (tgt_claim) begin
            write_q   <= pin_in.cbe[ppp_pkg::CMD_WRITE_BIT];
            retry_q   <= tgt_retry;
            cfg_reg_q <= pin_in.ad[ppp_pkg::CFG_REG_LSB +: 6];
         end
         if (tgt_q == ppp_pkg::T_DECODE) begin
            cfg_rdata_q <= cfg_rdata;
         end
      end
   end

   // Config write delivery
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_wr_q    <= 1'b0;
         cfg_wdata_q <= 32'h0;
         cfg_be_q    <= 4'h0;
      end else begin
         cfg_wr_q <= tgt_xfer && write_q;
         if (tgt_xfer && write_q) begin
            cfg_wdata_q <= pin_in.ad;
            cfg_be_q    <= ~pin_in.cbe;
         end
      end
   end

   // Target control pins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         devsel_o_q  <= 1'b1;
         devsel_oe_q <= 1'b0;
         trdy_o_q    <= 1'b1;
         trdy_oe_q   <= 1'b0;
         stop_o_q    <= 1'b1;
         stop_oe_q   <= 1'b0;
      end else begin
         devsel_o_q  <= tgt_d == ppp_pkg::T_IDLE || tgt_d == ppp_pkg::T_TURN;
         devsel_oe_q <= tgt_d != ppp_pkg::T_IDLE;
         trdy_o_q    <= !(tgt_d == ppp_pkg::T_DATA && !retry_q);
         trdy_oe_q   <= tgt_d != ppp_pkg::T_IDLE;
         stop_o_q    <= !((tgt_d == ppp_pkg::T_DATA && (retry_q || !pin_in.frame_n)) ||
                          tgt_d == ppp_pkg::T_HOLD);
         stop_oe_q   <= tgt_d != ppp_pkg::T_IDLE;
      end
   end

   // Address, command and parity drive
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ad_o_q   <= 32'h0;
         ad_oe_q  <= 1'b0;
         cbe_o_q  <= 4'h0;
         cbe_oe_q <= 1'b0;
         par_o_q  <= 1'b0;
         par_oe_q <= 1'b0;
      end else begin
         if (mst_d == ppp_pkg::M_ADDR) begin
            ad_o_q  <= mst_req_data.addr;
            cbe_o_q <= mst_req_data.cmd;
         end else if (mst_d == ppp_pkg::M_DATA) begin
            ad_o_q  <= req_q.wdata;
            cbe_o_q <= ~req_q.be;
         end else begin
            ad_o_q  <= (tgt_q == ppp_pkg::T_DECODE) ? cfg_rdata : cfg_rdata_q;
            cbe_o_q <= 4'h0;
         end
         ad_oe_q  <= mst_d == ppp_pkg::M_ADDR ||
                     (mst_d == ppp_pkg::M_DATA && req_q.cmd[ppp_pkg::CMD_WRITE_BIT]) ||
                     (tgt_d == ppp_pkg::T_DATA && !write_q && !retry_q);
         cbe_oe_q <= mst_d == ppp_pkg::M_ADDR || mst_d == ppp_pkg::M_DATA;
         par_o_q  <= ^{ad_o_q, pin_in.cbe};
         par_oe_q <= ad_oe_q;
      end
   end

   // Parity checks on received address and data
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_prev_q <= 1'b1;
         data_chk_q   <= 1'b0;
         data_par_q   <= 1'b0;
         addr_chk_q   <= 1'b0;
         addr_par_q   <= 1'b0;
      end else begin
         frame_prev_q <= pin_in.frame_n;
         data_chk_q   <= (tgt_xfer && write_q) || mst_rx;
         data_par_q   <= ^{pin_in.ad, pin_in.cbe};
         addr_chk_q   <= addr_phase && mst_q != ppp_pkg::M_ADDR;
         addr_par_q   <= ^{pin_in.ad, pin_in.cbe};
      end
   end

   // Parity error: low one cycle, high one cycle, then released
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         perr_o_q  <= 1'b1;
         perr_oe_q <= 1'b0;
      end else if (data_perr) begin
         perr_o_q  <= 1'b0;
         perr_oe_q <= 1'b1;
      end else if (perr_oe_q && !perr_o_q) begin
         perr_o_q  <= 1'b1;
      end else begin
         perr_oe_q <= 1'b0;
      end
   end

   // System error, open drain
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ss_meta_q <= 1'b1;
         ss_sync_q <= 1'b1;
         serr_o_q  <= 1'b0;
         serr_oe_q <= 1'b0;
      end else begin
         ss_meta_q <= secondary_system_error_n;
         ss_sync_q <= ss_meta_q;
         serr_o_q  <= 1'b0;
         serr_oe_q <= addr_perr || !ss_sync_q || dt_master_timeout;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   irdy_hold_a: assert property (mst_q == ppp_pkg::M_DATA && !mst_end && !mst_timeout
      |=> !irdy_o_q && irdy_oe_q) else $error("initiator ready dropped early");
   trdy_hold_a: assert property (!trdy_o_q && trdy_oe_q &&
      pin_in.primary_initiator_ready_n |=> !trdy_o_q) else $error("target ready dropped early");
   sts_devsel_a: assert property ($rose(devsel_o_q) && devsel_oe_q
      |=> !devsel_oe_q) else $error("device select not released after one high cycle");
   sts_irdy_a: assert property ($fell(irdy_oe_q) |-> $past(irdy_o_q))
      else $error("initiator ready released while low");
   devsel_timeout_a: assert property ($rose(mst_q == ppp_pkg::M_DATA) ##0
      pin_in.primary_device_select_n [*5] |=> mst_done_q && mst_abort_q)
      else $error("missing master abort");
   claim_devsel_a: assert property (tgt_claim |=> !devsel_o_q && devsel_oe_q)
      else $error("claimed access without device select");
   stop_end_a: assert property (mst_q == ppp_pkg::M_DATA && !pin_in.stop_n &&
      !pin_in.primary_device_select_n |=> mst_q == ppp_pkg::M_TURN && mst_stopped_q)
      else $error("stop not honoured");
   lock_wait_a: assert property (mst_q == ppp_pkg::M_IDLE && !pin_in.lock_n
      |=> mst_q == ppp_pkg::M_IDLE) else $error("master started under lock");
   idsel_claim_a: assert property ($rose(tgt_q == ppp_pkg::T_DECODE)
      |-> $past(pin_in.primary_config_select)) else $error("claim without config select");
   perr_drive_a: assert property (data_perr |=> !perr_o_q && perr_oe_q)
      else $error("data parity error not reported");
   serr_drive_a: assert property (!ss_sync_q || dt_master_timeout
      |=> serr_oe_q && !serr_o_q) else $error("system error not driven");
   frame_end_a: assert property (mst_q == ppp_pkg::M_ADDR |=> frame_o_q && frame_oe_q
      ##1 !frame_oe_q) else $error("frame not ended for single phase");
   par_gen_a: assert property (ad_oe_q |=> par_oe_q &&
      par_o_q == ^{$past(ad_o_q), $past(pin_in.cbe)}) else $error("bad driven parity");

   mst_ok_c: cover property (mst_done_q && !mst_abort_q && !mst_stopped_q);
   mst_abort_c: cover property (mst_done_q && mst_abort_q);
   cfg_write_c: cover property (cfg_wr_q);
   tgt_retry_c: cover property (tgt_q == ppp_pkg::T_DATA && retry_q && !stop_o_q);
endmodule : ppp_primary_port

// ---- ppp_pkg.sv ----
// Constants and pin bundles for the primary PCI port
// What this block does
// - An initiator holds its ready line asserted until the data phase completes.
// - The target holds its ready line asserted until the data phase ends.
// - Sustained control lines are driven high one cycle before being released.
// - As master, abort when device select is missing five clocks after frame.
// - A target accepting a transaction asserts device select; so does this port.
// - A target asserts stop to end a transaction; the initiator then terminates.
// - Type 0 configuration accesses are claimed only while config select is high.
// - Parity error is asserted when received data carries bad parity.
// - System error is pulled low on address parity, secondary error or timeout.
// - Frame marks the start and lasts until the final data phase.
// - Parity is even over data, command and parity, valid one clock later.
package ppp_pkg;
   localparam logic [3:0] CMD_CFG_READ    = 4'ha;
   localparam logic [3:0] CMD_CFG_WRITE   = 4'hb;
   localparam logic [1:0] CFG_TYPE0       = 2'h0;
   localparam int         CMD_WRITE_BIT   = 0;
   localparam int         CFG_REG_LSB     = 2;
   localparam logic [2:0] DEVSEL_WAIT_CYC = 3'h5;
   localparam logic [2:0] CNT_FIRST       = 3'h1;

   typedef struct packed {
      logic [31:0] ad;
      logic [3:0]  cbe;
      logic        primary_parity;
      logic        frame_n;
      logic        primary_initiator_ready_n;
      logic        primary_target_ready_n;
      logic        primary_device_select_n;
      logic        stop_n;
      logic        lock_n;
      logic        primary_config_select;
   } ppp_pins_in_type;

   typedef struct packed {
      logic [31:0] ad_o;
      logic        ad_oe;
      logic [3:0]  cbe_o;
      logic        cbe_oe;
      logic        par_o;
      logic        par_oe;
      logic        frame_o;
      logic        frame_oe;
      logic        irdy_o;
      logic        irdy_oe;
      logic        trdy_o;
      logic        trdy_oe;
      logic        devsel_o;
      logic        devsel_oe;
      logic        stop_o;
      logic        stop_oe;
      logic        perr_o;
      logic        perr_oe;
      logic        serr_o;
      logic        serr_oe;
   } ppp_pins_out_type;

   typedef struct packed {
      logic [3:0]  cmd;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0]  be;
   } ppp_mst_req_type;

   typedef enum logic [3:0] {
      M_IDLE = 4'b0001,
      M_ADDR = 4'b0010,
      M_DATA = 4'b0100,
      M_TURN = 4'b1000
   } ppp_mst_state_type;

   typedef enum logic [4:0] {
      T_IDLE   = 5'b00001,
      T_DECODE = 5'b00010,
      T_DATA   = 5'b00100,
      T_HOLD   = 5'b01000,
      T_TURN   = 5'b10000
   } ppp_tgt_state_type;
endpackage : ppp_pkg

// ---- ppp_far_agent.sv ----
// Far-side primary bus agent: target, config initiator and wire resolution
`timescale 1ns/1ps
module ppp_far_agent (
   input  wire ppp_pkg::ppp_pins_out_type pin_out,
   input  wire logic                      clk,
   output ppp_pkg::ppp_pins_in_type       pin_in
);
   logic [1:0]  mode = 2'h0;
   logic [31:0] rd_val = 32'h0;
   logic        lock_n = 1'b1;
   logic        sel = 1'b0;
   logic        burst = 1'b0;
   logic [31:0] ad_q = 32'h0;
   logic [3:0]  cbe_q = 4'h0;
   logic        ad_oe = 1'b0;
   logic        cbe_oe = 1'b0;
   logic        par_q = 1'b0;
   logic        par_oe = 1'b0;
   logic        frame_q = 1'b1;
   logic        irdy_q = 1'b1;
   logic        devsel_q = 1'b1;
   logic        trdy_q = 1'b1;
   logic        stop_q = 1'b1;
   logic [36:0] last_q = '0;
   int          t_st = 0;
   int          t_cnt = 0;

   // Released lines without pull-up toggle every cycle
   always @(posedge clk) last_q <= {pin_in.ad, pin_in.cbe, pin_in.primary_parity};

   always_comb begin
      pin_in.ad = pin_out.ad_oe ? pin_out.ad_o : (ad_oe ? ad_q : ~last_q[36:5]);
      pin_in.cbe = pin_out.cbe_oe ? pin_out.cbe_o : (cbe_oe ? cbe_q : ~last_q[4:1]);
      pin_in.primary_parity = pin_out.par_oe ? pin_out.par_o : (par_oe ? par_q : ~last_q[0]);
      pin_in.frame_n = (pin_out.frame_o | !pin_out.frame_oe) & frame_q;
      pin_in.primary_initiator_ready_n = (pin_out.irdy_o | !pin_out.irdy_oe) & irdy_q;
      pin_in.primary_target_ready_n = (pin_out.trdy_o | !pin_out.trdy_oe) & trdy_q;
      pin_in.primary_device_select_n = (pin_out.devsel_o | !pin_out.devsel_oe) & devsel_q;
      pin_in.stop_n = (pin_out.stop_o | !pin_out.stop_oe) & stop_q;
      pin_in.lock_n = lock_n;
      pin_in.primary_config_select = sel;
   end

   // Target for the port's master: 0 fast, 1 slow, 2 stop, 3 silent
   always @(negedge clk) begin
      case (t_st)
         0: if (pin_out.frame_oe && !pin_out.frame_o) begin
               t_st = (mode == 2'h3) ? 0 : 1;
               t_cnt = (mode == 2'h1) ? 2 : 0;
            end
         1: if (t_cnt > 0) begin
               t_cnt--;
            end else begin
               devsel_q = 1'b0;
               stop_q = (mode != 2'h2);
               trdy_q = (mode == 2'h2);
               ad_q = rd_val;
               ad_oe = !pin_out.ad_oe && mode != 2'h2;
               par_q = ^{rd_val, pin_in.cbe};
               t_st = 2;
            end
         2: begin
               devsel_q = 1'b1;
               trdy_q = 1'b1;
               stop_q = 1'b1;
               par_oe = ad_oe;
               ad_oe = 1'b0;
               t_st = 3;
            end
         default: begin
            par_oe = 1'b0;
            t_st = 0;
         end
      endcase
   end

   // Configuration access as initiator: one data phase, or two when burst is set
   task automatic cfg_access(input logic s, input logic wr, input logic [5:0] rg,
                             input logic [31:0] wd, input logic [1:0] bad,
                             output logic [31:0] rd, output logic pok);
      int n;
      @(negedge clk);
      sel = s;
      frame_q = 1'b0;
      ad_q = {24'h0, rg, 2'b00};
      cbe_q = wr ? ppp_pkg::CMD_CFG_WRITE : ppp_pkg::CMD_CFG_READ;
      ad_oe = 1'b1;
      cbe_oe = 1'b1;
      @(negedge clk);
      par_q = ^{ad_q, cbe_q} ^ bad[0];
      par_oe = 1'b1;
      frame_q = !burst;
      irdy_q = 1'b0;
      sel = 1'b0;
      ad_q = wd;
      ad_oe = wr;
      cbe_q = 4'h0;
      n = 0;
      while (pin_in.primary_target_ready_n && pin_in.stop_n && n < 8) begin
         @(negedge clk);
         par_oe = 1'b0;
         n++;
      end
      rd = pin_in.ad;
      @(negedge clk);
      pok = ~^{rd, 4'h0, pin_in.primary_parity};
      par_q = ^{wd, 4'h0} ^ bad[1];
      par_oe = wr;
      ad_oe = 1'b0;
      cbe_oe = 1'b0;
      if (!frame_q) begin
         frame_q = 1'b1;
         @(negedge clk);
         par_oe = 1'b0;
      end
      irdy_q = 1'b1;
      @(negedge clk);
      par_oe = 1'b0;
   endtask : cfg_access
endmodule : ppp_far_agent

// ---- tb_pci_primary_port_signaling.sv ----
// Self-checking bench for the primary PCI port
`timescale 1ns/1ps
module tb_pci_primary_port_signaling;
   typedef struct packed {
      logic [3:0]  cmd;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [1:0]  mode;
      logic        abort;
      logic        stopped;
   } ppp_row_type;
   localparam ppp_row_type ROWS [6] = '{
      '{4'h7, 32'h0000_1000, 32'h1234_5678, 2'h0, 1'b0, 1'b0},
      '{4'h6, 32'h0000_2004, 32'h0, 2'h0, 1'b0, 1'b0},
      '{4'h7, 32'h0000_3008, 32'hfedc_ba98, 2'h1, 1'b0, 1'b0},
      '{4'h6, 32'h0000_400c, 32'h0, 2'h1, 1'b0, 1'b0},
      '{4'h7, 32'h0000_5010, 32'h0f0f_0f0f, 2'h2, 1'b0, 1'b1},
      '{4'h6, 32'h0000_6014, 32'h0, 2'h3, 1'b1, 1'b0}};
   logic                      clk = 1'b0;
   logic                      rst_b = 1'b0;
   ppp_pkg::ppp_pins_in_type  pin_in;
   ppp_pkg::ppp_pins_out_type pin_out;
   logic                      mst_req = 1'b0;
   ppp_pkg::ppp_mst_req_type  mst_req_data = '0;
   logic                      mst_busy_q, mst_done_q, mst_abort_q, mst_stopped_q, cfg_wr_q, pok;
   logic [31:0]               mst_rdata_q, cfg_wdata_q, rd;
   logic                      tgt_retry = 1'b0;
   logic [31:0]               cfg_rdata = 32'h0;
   logic [5:0]                cfg_reg_q;
   logic [3:0]                cfg_be_q;
   logic                      sec_err_n = 1'b1;
   logic                      dt_timeout = 1'b0;
   int                        failures = 0, tests_run = 0, cycles = 0, snap = 0;
   int                        wr_cnt = 0, perr_cnt = 0, serr_cnt = 0, dev_cnt = 0, stop_cnt = 0;
   wire [9:0] oe_bits = {pin_out.ad_oe, pin_out.cbe_oe, pin_out.par_oe, pin_out.frame_oe,
      pin_out.irdy_oe, pin_out.trdy_oe, pin_out.devsel_oe, pin_out.stop_oe, pin_out.perr_oe,
      pin_out.serr_oe};

   ppp_primary_port i_dut (.clk(clk), .rst_b(rst_b), .pin_in(pin_in), .pin_out(pin_out),
      .mst_req(mst_req), .mst_req_data(mst_req_data), .mst_busy_q(mst_busy_q),
      .mst_done_q(mst_done_q), .mst_abort_q(mst_abort_q), .mst_stopped_q(mst_stopped_q),
      .mst_rdata_q(mst_rdata_q), .tgt_retry(tgt_retry), .cfg_rdata(cfg_rdata),
      .cfg_reg_q(cfg_reg_q), .cfg_wdata_q(cfg_wdata_q), .cfg_be_q(cfg_be_q),
      .cfg_wr_q(cfg_wr_q), .secondary_system_error_n(sec_err_n),
      .dt_master_timeout(dt_timeout));
   ppp_far_agent i_far (.pin_out(pin_out), .clk(clk), .pin_in(pin_in));

   always #50 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         report_and_stop;
      end
   end

   // Event counters on the port's outputs
   always @(negedge clk) begin
      if (cfg_wr_q === 1'b1) wr_cnt++;
      if (pin_out.perr_oe === 1'b1 && pin_out.perr_o === 1'b0) perr_cnt++;
      if (pin_out.serr_oe === 1'b1) serr_cnt++;
      if (pin_out.devsel_oe === 1'b1 && pin_out.devsel_o === 1'b0) dev_cnt++;
      if (pin_out.stop_oe === 1'b1 && pin_out.stop_o === 1'b0) stop_cnt++;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task report_and_stop;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop

   task automatic mst_run(input ppp_row_type r);
      int n;
      i_far.mode = r.mode;
      i_far.rd_val = ~r.addr;
      mst_req_data = '{r.cmd, r.addr, r.wdata, 4'hf};
      mst_req = 1'b1;
      n = 0;
      while (mst_busy_q !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      mst_req = 1'b0;
      n = 0;
      while (mst_done_q !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      check("m_done_wait", n <= 8, 1'b1);
      check("m_abort", mst_abort_q, r.abort);
      check("m_stopped", mst_stopped_q, r.stopped);
      if (!r.cmd[0] && !r.abort) check("m_rdata", mst_rdata_q, ~r.addr);
      while (mst_busy_q !== 1'b0 && n < 40) begin
         @(negedge clk);
         n++;
      end
      repeat (2) @(negedge clk);
   endtask : mst_run

   task automatic acc(input logic s, input logic wr, input logic [5:0] rg,
                      input logic [31:0] wd, input logic [1:0] bad);
      i_far.cfg_access(s, wr, rg, wd, bad, rd, pok);
      repeat (4) @(negedge clk);
   endtask : acc

   initial begin
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      check("reset_oe", oe_bits, 10'h0);
      foreach (ROWS[i]) mst_run(ROWS[i]);
      check("read_perr", perr_cnt, 0);
      acc(1'b1, 1'b1, 6'h05, 32'hcafe_0001, 2'h0);
      check("cfg_wr", wr_cnt, 1);
      check("cfg_reg", cfg_reg_q, 6'h05);
      check("cfg_wdata", cfg_wdata_q, 32'hcafe_0001);
      check("cfg_be", cfg_be_q, 4'hf);
      cfg_rdata = 32'h5a5a_00ff;
      acc(1'b1, 1'b0, 6'h02, 32'h0, 2'h0);
      check("cfg_rd", rd, 32'h5a5a_00ff);
      check("rd_parity", pok, 1'b1);
      snap = dev_cnt;
      acc(1'b0, 1'b1, 6'h05, 32'h1, 2'h0);
      check("no_sel_dev", dev_cnt - snap, 0);
      check("no_sel_wr", wr_cnt, 1);
      acc(1'b1, 1'b1, 6'h06, 32'h3, 2'h2);
      check("data_perr", perr_cnt, 1);
      snap = serr_cnt;
      acc(1'b1, 1'b1, 6'h07, 32'h4, 2'h1);
      check("addr_serr", serr_cnt - snap, 1);
      tgt_retry = 1'b1;
      snap = wr_cnt;
      acc(1'b1, 1'b1, 6'h08, 32'h5, 2'h0);
      tgt_retry = 1'b0;
      check("retry_stop", stop_cnt > 0, 1'b1);
      check("retry_wr", wr_cnt - snap, 0);
      snap = stop_cnt;
      i_far.burst = 1'b1;
      acc(1'b1, 1'b1, 6'h09, 32'h6, 2'h0);
      i_far.burst = 1'b0;
      check("burst_stop", stop_cnt - snap, 2);
      check("burst_wdata", cfg_wdata_q, 32'h6);
      i_far.lock_n = 1'b0;
      mst_req_data = '{ROWS[0].cmd, ROWS[0].addr, ROWS[0].wdata, 4'hf};
      mst_req = 1'b1;
      repeat (10) @(negedge clk);
      check("lock_busy", mst_busy_q, 1'b0);
      i_far.lock_n = 1'b1;
      mst_run(ROWS[0]);
      snap = serr_cnt;
      sec_err_n = 1'b0;
      repeat (8) @(negedge clk);
      sec_err_n = 1'b1;
      repeat (5) @(negedge clk);
      dt_timeout = 1'b1;
      @(negedge clk);
      dt_timeout = 1'b0;
      repeat (4) @(negedge clk);
      check("serr_cycles", serr_cnt - snap, 9);
      rst_b = 1'b0;
      @(negedge clk);
      check("rst_oe", oe_bits, 10'h0);
      check("rst_busy", mst_busy_q, 1'b0);
      rst_b = 1'b1;
      repeat (2) @(negedge clk);
      mst_run(ROWS[1]);
      report_and_stop;
   end
endmodule : tb_pci_primary_port_signaling
